// ===== common/acq_params.svh
// Constants for the acquisition control link, device and host controller
`ifndef ACQ_PARAMS_SVH
`define ACQ_PARAMS_SVH

`define ACQ_CLK_HZ        100000000
`define ACQ_LPOSC_HZ      262000
`define ACQ_MOD_HZ        1024000
`define ACQ_CHOP_HZ       2000
`define ACQ_RATIO1        64
`define ACQ_RATIO2        4
`define ACQ_INIT_TIME_US  500
`define ACQ_STAB_TIME_US  1500
`define ACQ_INIT_CYC      (`ACQ_INIT_TIME_US * (`ACQ_CLK_HZ / 1000000))
`define ACQ_STAB_CYC      (`ACQ_STAB_TIME_US * (`ACQ_CLK_HZ / 1000000))
`define ACQ_LPOSC_HALF    (`ACQ_CLK_HZ / (2 * `ACQ_LPOSC_HZ))

`define REG_MODE          8'h01
`define REG_STATUS        8'h02
`define REG_DATA          8'h03
`define REG_RESET         8'h09
`define REG_GAIN          8'h13
`define REG_PD2           8'h15
`define REG_CHSEL         8'h17
`define REG_ISC           8'h18

`define RST_FULL_BIT      7
`define RST_MEAS_BIT      6
`define RESET_CTRL_RST    8'hc0
`define MODE_RUN_BIT      0
`define MODE_EXTCLK_BIT   1
`define ST_NEW_BIT        0
`define ST_INVALID_BIT    1
`define ST_LATE_BIT       2

`define HC_CMD            2'h0
`define HC_RESULT         2'h1
`define HC_SAMPLE         2'h2
`define HC_CTRL           2'h3

`endif

// ===== common/acq_pkg.sv
// Types shared by the acquisition device and its host controller
package acq_pkg;

  typedef enum logic [3:0] {
    D_INIT = 4'h1,
    D_STOP = 4'h2,
    D_STAB = 4'h4,
    D_RUN  = 4'h8
  } dev_mode_t;

  typedef enum logic [2:0] {
    H_IDLE  = 3'h1,
    H_REQ   = 3'h2,
    H_INITW = 3'h4
  } host_mode_t;

  typedef struct packed {
    logic       we;
    logic [7:0] addr;
    logic [7:0] data;
  } link_op_t;

endpackage : acq_pkg

// ===== common/acq_link_if.sv
// Register link and interrupt line between host controller and device
interface acq_link_if;
  logic       req;
  logic       we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       ack;
  logic [7:0] rdata;
  logic       irq;
  logic       ext_clk_en;

  modport dev  (input req, we, addr, wdata, ext_clk_en, output ack, rdata, irq);
  modport host (output req, we, addr, wdata, ext_clk_en, input ack, rdata, irq);
endinterface : acq_link_if

// ===== design/tick_div.sv
// Divider giving a one-cycle enable pulse every DIV cycles
module tick_div #(
  parameter int DIV = 4
) (
  input  wire logic clk_in,   // System clock
  input  wire logic rstn_in,  // Synchronous reset, active low
  input  wire logic clr_in,   // Restart the count
  output logic      tick_out  // One-cycle enable
);
  if (DIV < 1) begin : g_chk
    $error("tick_div: DIV must be at least 1");
  end

  logic [23:0] cnt_q;

  always_ff @(posedge clk_in) begin
    if (!rstn_in || clr_in || cnt_q == 24'(DIV - 1)) begin
      cnt_q <= 24'h0;
    end else begin
      cnt_q <= cnt_q + 24'h1;
    end
  end

  always_ff @(posedge clk_in) begin
    tick_out <= rstn_in && !clr_in && cnt_q == 24'(DIV - 1);
  end
endmodule : tick_div

// ===== design/acq_device.sv
// Acquisition device: register file, reset handling and sample timing
`include "acq_params.svh"
module acq_device import acq_pkg::*; #(
  parameter int MOD_HZ   = `ACQ_MOD_HZ,
  parameter int CHOP_HZ  = `ACQ_CHOP_HZ,
  parameter int RATIO1   = `ACQ_RATIO1,
  parameter int RATIO2   = `ACQ_RATIO2,
  parameter int INIT_CYC = `ACQ_INIT_CYC,
  parameter int STAB_CYC = `ACQ_STAB_CYC
) (
  input  wire logic   clk_in,    // System clock, 100 MHz
  input  wire logic   rstn_in,   // Synchronous reset, active low
  acq_link_if.dev     link,      // Register link toward the host
  output logic        running_out // Conversions in progress
);
  localparam int HALF_CHOP  = `ACQ_CLK_HZ / (2 * CHOP_HZ);
  localparam int SAMPLE_CYC = HALF_CHOP * RATIO2;
  localparam int WIN_CYC    = HALF_CHOP
                              - (5 * RATIO1 * (`ACQ_CLK_HZ / 1000)) / (2 * (MOD_HZ / 1000));

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // A time-compressed pairing must keep a tabulated clock-to-ratio proportion
  localparam bit SCALED_OK = MOD_HZ > 2048000 && MOD_HZ % CHOP_HZ == 0 &&
                             (MOD_HZ / CHOP_HZ == 8 * RATIO1 ||
                              MOD_HZ / CHOP_HZ == 16 * RATIO1);
  if (!((MOD_HZ == 1024000 && CHOP_HZ == 2000 && RATIO1 == 64) ||
        (MOD_HZ == 2048000 && CHOP_HZ == 2000 && RATIO1 == 64) ||
        (MOD_HZ == 2048000 && CHOP_HZ == 2000 && RATIO1 == 128) ||
        (MOD_HZ == 2048000 && CHOP_HZ == 4000 && RATIO1 == 64) ||
        SCALED_OK)) begin : g_combo
    $error("acq_device: clock and ratio pairing not supported");
  end
  if (INIT_CYC < 1 || STAB_CYC < 1 || SAMPLE_CYC >= (1 << 24) || WIN_CYC < 1 ||
      INIT_CYC >= (1 << 24) || STAB_CYC >= (1 << 24)) begin : g_cnt
    $error("acq_device: counts out of range");
  end

  typedef struct packed {
    dev_mode_t   mode;
    logic [23:0] cnt;
    logic [7:0]  rst_ctrl;
    logic [7:0]  gain;
    logic [7:0]  pd2;
    logic [7:0]  chsel;
    logic [7:0]  isc;
    logic [7:0]  mode_reg;
    logic [7:0]  status;
    logic [7:0]  data;
    logic        gain_dirty;
    logic        irq;
    logic        ack;
    logic [7:0]  rdata;
  } dev_state_t;

  dev_state_t s_q;
  dev_state_t s_d;
  logic       lp_tick;

  // Slow oscillator stand-in; only drives the interrupt toggling at init
  tick_div #(
    .DIV (`ACQ_LPOSC_HALF)
  ) u_lposc (
    .clk_in   (clk_in),
    .rstn_in  (rstn_in),
    .clr_in   (1'b0),
    .tick_out (lp_tick)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic       acc;
    logic       wr;
    logic       rd;
    logic       live;
    logic       adv;
    logic [7:0] st_set;
    acc    = link.req && !s_q.ack;
    wr     = acc && link.we;
    rd     = acc && !link.we;
    live   = s_q.mode == D_RUN || s_q.mode == D_STAB;
    adv    = !s_q.mode_reg[`MODE_EXTCLK_BIT] || link.ext_clk_en;
    st_set = 8'h00;
    s_d    = s_q;
    s_d.ack = acc;

    unique case (s_q.mode)
      D_INIT: begin
        if (lp_tick) begin
          s_d.irq = !s_q.irq;
        end
        s_d.cnt = s_q.cnt + 24'h1;
        if (s_q.cnt == 24'(INIT_CYC - 1)) begin
          s_d.mode = D_STOP;
          s_d.cnt  = 24'h0;
          s_d.irq  = 1'b0;
        end
      end
      D_STOP: begin
        s_d.irq = 1'b0;
      end
      D_STAB: begin
        if (adv) begin
          s_d.cnt = s_q.cnt + 24'h1;
        end
        if (s_q.cnt == 24'(STAB_CYC - 1)) begin
          s_d.mode = D_RUN;
          s_d.cnt  = 24'h0;
        end
      end
      D_RUN: begin
        if (adv) begin
          s_d.cnt = s_q.cnt + 24'h1;
        end
        if (s_q.cnt == 24'(WIN_CYC - 1)) begin
          s_d.irq = 1'b0;
        end
        if (s_q.cnt == 24'(SAMPLE_CYC - 1)) begin
          s_d.cnt  = 24'h0;
          s_d.data = s_q.data + 8'h01;
          s_d.irq  = 1'b1;
          st_set[`ST_NEW_BIT] = 1'b1;
          if (s_q.gain_dirty) begin
            st_set[`ST_INVALID_BIT] = 1'b1;
            s_d.gain_dirty = 1'b0;
          end
        end
      end
    endcase

    // Reading after the window has closed disturbs the next sample
    if (rd && s_q.mode == D_RUN && s_q.cnt >= 24'(WIN_CYC) &&
        (link.addr == `REG_DATA || link.addr == `REG_STATUS)) begin
      st_set[`ST_LATE_BIT] = 1'b1;
    end

    if (rd) begin
      unique case (link.addr)
        `REG_MODE:   s_d.rdata = s_q.mode_reg;
        `REG_STATUS: s_d.rdata = s_q.status;
        `REG_DATA:   s_d.rdata = s_q.data;
        `REG_RESET:  s_d.rdata = s_q.rst_ctrl;
        `REG_GAIN:   s_d.rdata = s_q.gain;
        `REG_PD2:    s_d.rdata = s_q.pd2;
        `REG_CHSEL:  s_d.rdata = s_q.chsel;
        `REG_ISC:    s_d.rdata = s_q.isc;
        default:     s_d.rdata = 8'h00;
      endcase
    end

    // Set wins over the clear done by the read
    s_d.status = ((rd && link.addr == `REG_STATUS) ? 8'h00 : s_q.status) | st_set;

    if (wr && s_q.mode != D_INIT) begin
      unique case (link.addr)
        `REG_GAIN: begin
          s_d.gain = link.wdata;
          if (live) begin
            s_d.gain_dirty = 1'b1;
          end
        end
        `REG_PD2:   s_d.pd2   = link.wdata;
        `REG_CHSEL: s_d.chsel = link.wdata;
        `REG_ISC:   s_d.isc   = link.wdata;
        `REG_MODE: begin
          s_d.mode_reg = live ? {s_q.mode_reg[7:1], link.wdata[0]} : link.wdata;
          if (!link.wdata[`MODE_RUN_BIT]) begin
            s_d.mode = D_STOP;
            s_d.cnt  = 24'h0;
            s_d.irq  = 1'b0;
          end else if (!live) begin
            s_d.mode = D_STAB;
            s_d.cnt  = 24'h0;
          end
        end
        `REG_RESET: begin
          if (!link.wdata[`RST_MEAS_BIT]) begin
            s_d.status     = 8'h00;
            s_d.data       = 8'h00;
            s_d.gain_dirty = 1'b0;
            s_d.cnt        = 24'h0;
            s_d.irq        = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // Whole-device reset beats any other write effect
    if (wr && link.addr == `REG_RESET && !link.wdata[`RST_FULL_BIT]) begin
      s_d          = '0;
      s_d.mode     = D_INIT;
      s_d.rst_ctrl = `RESET_CTRL_RST;
      s_d.ack      = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      s_q          <= '0;
      s_q.mode     <= D_INIT;
      s_q.rst_ctrl <= `RESET_CTRL_RST;
    end else begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge clk_in) begin
    running_out <= rstn_in && s_d.mode == D_RUN;
  end

  assign link.ack   = s_q.ack;
  assign link.rdata = s_q.rdata;
  assign link.irq   = s_q.irq;
endmodule : acq_device

// ===== design/acq_host.sv
// Host controller: Avalon-MM command registers driving the device link
`include "acq_params.svh"
module acq_host import acq_pkg::*; #(
  parameter int INIT_CYC = `ACQ_INIT_CYC
) (
  input  wire logic        clk_in,          // System clock, 100 MHz
  input  wire logic        rstn_in,         // Synchronous reset, active low
  input  wire logic [3:0]  avs_address,     // Byte address
  input  wire logic        avs_read,        // Read request
  input  wire logic        avs_write,       // Write request
  input  wire logic [31:0] avs_writedata,   // Write data
  output logic [31:0]      avs_readdata,    // Read data
  output logic             avs_waitrequest, // Stall
  acq_link_if.host         link             // Link toward the device
);
  if (INIT_CYC < 1 || INIT_CYC >= (1 << 24)) begin : g_chk
    $error("acq_host: INIT_CYC out of range");
  end

  typedef struct packed {
    host_mode_t        mode;
    link_op_t [2:0]    ops;
    logic [1:0]        nops;
    logic [1:0]        idx;
    logic [23:0]       cnt;
    logic              running;
    logic              skip;
    logic              full_rst;
    logic              meas_rst;
    logic              autoread;
    logic              clk_en;
    logic              irq_prev;
    logic              irq_pend;
    logic [7:0]        last_rd;
    logic [7:0]        smp_data;
    logic [7:0]        smp_stat;
    logic [7:0]        smp_cnt;
    logic              wait_r;
    logic [31:0]       rdata;
  } host_state_t;

  host_state_t s_q;
  host_state_t s_d;

  always_comb begin
    logic     req;
    logic     cmd;
    link_op_t op;
    logic     dyn;
    req = (avs_read || avs_write) && s_q.wait_r;
    cmd = avs_write && avs_address[3:2] == `HC_CMD;
    op  = '{we: avs_writedata[16], addr: avs_writedata[15:8], data: avs_writedata[7:0]};
    dyn = op.addr == `REG_GAIN || op.addr == `REG_PD2 || op.addr == `REG_CHSEL ||
          op.addr == `REG_ISC || op.addr == `REG_MODE;
    s_d        = s_q;
    s_d.wait_r = 1'b1;
    s_d.irq_prev = link.irq;
    if (link.irq && !s_q.irq_prev && s_q.mode != H_INITW) begin
      s_d.irq_pend = 1'b1;
    end

    // ----------------------------------------------------------------
    // Avalon slave; a command stalls until the link is free
    // ----------------------------------------------------------------
    if (req && !(cmd && s_q.mode != H_IDLE)) begin
      s_d.wait_r = 1'b0;
      unique case (avs_address[3:2])
        `HC_RESULT: s_d.rdata = {21'h0, s_q.mode == H_INITW, s_q.running,
                                 s_q.mode != H_IDLE, s_q.last_rd};
        `HC_SAMPLE: s_d.rdata = {s_q.smp_cnt, 8'h00, s_q.smp_stat, s_q.smp_data};
        `HC_CTRL: begin
          s_d.rdata = {31'h0, s_q.clk_en};
          if (avs_write) begin
            s_d.clk_en = avs_writedata[0];
          end
        end
        default: s_d.rdata = 32'h0;
      endcase
      if (cmd) begin
        s_d.mode     = H_REQ;
        s_d.idx      = 2'd0;
        s_d.autoread = 1'b0;
        s_d.full_rst = 1'b0;
        s_d.meas_rst = 1'b0;
        s_d.nops     = 2'd1;
        s_d.ops[0]   = op;
        if (op.we && op.addr == `REG_RESET && !op.data[`RST_FULL_BIT]) begin
          s_d.full_rst = 1'b1;
          s_d.running  = 1'b0;
        end else if (op.we && op.addr == `REG_RESET && !op.data[`RST_MEAS_BIT]) begin
          s_d.meas_rst = 1'b1;
          if (s_q.running) begin
            s_d.ops[0]  = '{we: 1'b1, addr: `REG_MODE, data: 8'h00};
            s_d.ops[1]  = op;
            s_d.nops    = 2'd2;
            s_d.running = 1'b0;
          end
        end else if (op.we && s_q.running && !dyn) begin
          s_d.ops[0] = '{we: 1'b1, addr: `REG_MODE, data: 8'h00};
          s_d.ops[1] = op;
          s_d.ops[2] = '{we: 1'b1, addr: `REG_MODE, data: 8'h01};
          s_d.nops   = 2'd3;
        end else if (op.we && op.addr == `REG_MODE) begin
          s_d.running = op.data[`MODE_RUN_BIT];
        end
        if (op.we && op.addr == `REG_GAIN && s_q.running) begin
          s_d.skip = 1'b1;
        end
      end
    end else if (s_q.mode == H_IDLE && s_q.irq_pend && s_q.running) begin
      // Read straight after the interrupt, well inside the window
      s_d.irq_pend = 1'b0;
      s_d.mode     = H_REQ;
      s_d.idx      = 2'd0;
      s_d.nops     = 2'd2;
      s_d.autoread = 1'b1;
      s_d.full_rst = 1'b0;
      s_d.meas_rst = 1'b0;
      s_d.ops[0]   = '{we: 1'b0, addr: `REG_DATA, data: 8'h00};
      s_d.ops[1]   = '{we: 1'b0, addr: `REG_STATUS, data: 8'h00};
    end else if (s_q.mode == H_IDLE && !s_q.running) begin
      s_d.irq_pend = s_q.irq_pend && link.irq && !s_q.irq_prev;
    end

    // ----------------------------------------------------------------
    // Link sequencer
    // ----------------------------------------------------------------
    unique case (s_q.mode)
      H_IDLE: begin
      end
      H_REQ: begin
        if (link.ack) begin
          s_d.last_rd = link.rdata;
          if (s_q.autoread && s_q.idx == 2'd0) begin
            s_d.smp_data = link.rdata;
          end
          if (s_q.autoread && s_q.idx == 2'd1) begin
            if (s_q.skip) begin
              s_d.skip = 1'b0;
            end else begin
              s_d.smp_stat = link.rdata;
              s_d.smp_cnt  = s_q.smp_cnt + 8'h01;
            end
          end
          s_d.idx = s_q.idx + 2'd1;
          if (s_q.idx + 2'd1 == s_q.nops) begin
            s_d.mode     = s_q.full_rst ? H_INITW : H_IDLE;
            s_d.cnt      = 24'h0;
            s_d.meas_rst = 1'b0;
          end
        end
      end
      H_INITW: begin
        s_d.irq_pend = 1'b0;
        s_d.cnt      = s_q.cnt + 24'h1;
        if (s_q.cnt == 24'(INIT_CYC - 1)) begin
          s_d.mode = H_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      s_q        <= '0;
      s_q.mode   <= H_INITW;
      s_q.wait_r <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Link drive straight from the state; request drops on the ack edge
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      link.req        <= 1'b0;
      link.we         <= 1'b0;
      link.addr       <= 8'h00;
      link.wdata      <= 8'h00;
      link.ext_clk_en <= 1'b0;
    end else begin
      link.req        <= s_d.mode == H_REQ && !(s_q.mode == H_REQ && link.ack);
      link.we         <= s_d.ops[s_d.idx].we;
      link.addr       <= s_d.ops[s_d.idx].addr;
      link.wdata      <= s_d.ops[s_d.idx].data;
      link.ext_clk_en <= s_d.clk_en && !s_d.meas_rst;
    end
  end

  assign avs_readdata    = s_q.rdata;
  assign avs_waitrequest = s_q.wait_r;
endmodule : acq_host

// ===== verification/acq_link_assertions.sv
// Concurrent checks on the host-to-device link and the interrupt line
`include "acq_params.svh"
module acq_link_assertions #(
  parameter int INIT_CYC   = 200,
  parameter int WIN_CYC    = 120,
  parameter int SAMPLE_CYC = 1280
) (
  input wire logic       clk_in,    // System clock
  input wire logic       rstn_in,   // Synchronous reset, active low
  input wire logic       req,       // Host request
  input wire logic       we,        // Write strobe
  input wire logic [7:0] addr,      // Register offset
  input wire logic [7:0] wdata,     // Write data
  input wire logic       ack,       // Device answer
  input wire logic       irq,       // Interrupt line
  input wire logic       ext_clk_en // External clock gate
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  // ----------------------------------------
  // Helper state
  // ----------------------------------------
  logic        irq_d_q, wrote_q, per_ok_q, live_q;
  logic [15:0] init_cnt_q, hi_cnt_q, per_cnt_q;
  wire         full_rst = ack && we && addr == `REG_RESET && !wdata[7];
  // Margin of 8 absorbs the skew between where each end starts its init count
  wire         quiet    = init_cnt_q == 16'(INIT_CYC + 8);
  wire         rise     = irq && !irq_d_q;

  always_ff @(posedge clk_in) begin
    irq_d_q   <= irq;
    hi_cnt_q  <= irq ? hi_cnt_q + 16'h1 : 16'h0;
    per_cnt_q <= rise ? 16'h1 : per_cnt_q + 16'h1;
    // A write inside a window may legally cut it short, so such windows are skipped
    wrote_q   <= irq ? (wrote_q || (req && we)) : 1'b0;
    if (!rstn_in || full_rst) init_cnt_q <= 16'h0;
    else if (!quiet) init_cnt_q <= init_cnt_q + 16'h1;
    if (!rstn_in || full_rst || !quiet || (req && we)) per_ok_q <= 1'b0;
    else if (rise) per_ok_q <= 1'b1;
    if (!rstn_in || full_rst) live_q <= 1'b0;
    else if (ack && we && addr == `REG_MODE) live_q <= wdata[0];
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  sequence s_open;  req && !ack;  endsequence
  sequence s_answer;  ack && req ##1 !ack && !req;  endsequence
  sequence s_meas_rst;  req && we && addr == `REG_RESET && wdata[7] && !wdata[6];  endsequence

  AST_LINK_HANDSHAKE: assert property (s_open |=> s_answer)
    else $error("link request not answered in one cycle");
  AST_REQ_FIELDS_HELD: assert property (s_open |=> $stable({we, addr, wdata}))
    else $error("link request fields changed before answer");
  AST_NO_REQ_IN_INIT: assert property (req |-> init_cnt_q == 16'h0 || init_cnt_q >= 16'(INIT_CYC - 4))
    else $error("link request during initialization");
  AST_IRQ_TOGGLES_IN_INIT: assert property (full_rst |-> ##[1:INIT_CYC] $changed(irq))
    else $error("interrupt line still during initialization");
  AST_MEAS_RST_CLK_OFF: assert property (s_meas_rst |-> !ext_clk_en)
    else $error("external clock enabled during path reset");
  AST_MEAS_RST_STOPPED: assert property (s_meas_rst |-> !live_q)
    else $error("path reset while running");
  AST_RECONFIG_STOPPED: assert property (req && we && !(addr inside {`REG_MODE, `REG_RESET,
    `REG_GAIN, `REG_PD2, `REG_CHSEL, `REG_ISC}) |-> !live_q)
    else $error("static register written while running");
  AST_READ_WINDOW: assert property ($fell(irq) && quiet && !wrote_q |-> hi_cnt_q == 16'(WIN_CYC))
    else $error("read window length wrong");
  AST_SAMPLE_PERIOD: assert property ($rose(irq) && per_ok_q |-> per_cnt_q == 16'(SAMPLE_CYC))
    else $error("sample period wrong");
endmodule : acq_link_assertions

// ===== verification/test_acquisition_reset_and_reconfig_control.sv
// Bench joining the host controller and the device over the link
`include "acq_params.svh"
module test_acquisition_reset_and_reconfig_control;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Scaled timing keeps the run to about ten thousand cycles
  // ----------------------------------------
  localparam int CLK_HZ     = 100000000;
  localparam int MOD_HZ     = 10000000;
  localparam int CHOP_HZ    = 156250;
  localparam int RATIO1     = 8;
  localparam int RATIO2     = 4;
  localparam int INIT_CYC   = 200;
  localparam int STAB_CYC   = 300;
  localparam int CPM        = CLK_HZ / MOD_HZ;
  // The 2.5 term is kept exact by multiplying by 5 before halving
  localparam int WIN_CYC    = CPM * (MOD_HZ / (2 * CHOP_HZ)) - CPM * RATIO1 * 5 / 2;
  localparam int SAMPLE_CYC = CLK_HZ / (2 * CHOP_HZ) * RATIO2;

  logic        clk_in = 1'b0;
  logic        rstn_in = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        running_out;
  logic        irq_was = 1'b0;
  int          failures = 0;
  int          check_count = 0;
  int          cycles = 0;
  int          toggles = 0;

  acq_link_if link ();
  acq_device #(.MOD_HZ(MOD_HZ), .CHOP_HZ(CHOP_HZ), .RATIO1(RATIO1), .RATIO2(RATIO2),
               .INIT_CYC(INIT_CYC), .STAB_CYC(STAB_CYC)) i_acq_device (
    .clk_in(clk_in), .rstn_in(rstn_in), .link(link), .running_out(running_out));
  acq_host #(.INIT_CYC(INIT_CYC)) i_acq_host (
    .clk_in(clk_in), .rstn_in(rstn_in), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .link(link));
  acq_link_assertions #(.INIT_CYC(INIT_CYC), .WIN_CYC(WIN_CYC), .SAMPLE_CYC(SAMPLE_CYC))
    i_acq_link_assertions (
    .clk_in(clk_in), .rstn_in(rstn_in), .req(link.req), .we(link.we), .addr(link.addr),
    .wdata(link.wdata), .ack(link.ack), .irq(link.irq), .ext_clk_en(link.ext_clk_en));

  always #5 clk_in = ~clk_in;

  always @(posedge clk_in) begin
    cycles++;
    if (link.irq !== irq_was) toggles++;
    irq_was = link.irq;
    if (cycles == 40000) begin
      failures++;
      close_out();
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic av_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d,
                         output logic [31:0] q);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= d;
    do @(posedge clk_in); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clk_in);
  endtask : av_xfer

  task automatic cmd(input logic wr, input logic [7:0] ra, input logic [7:0] d,
                     output logic [7:0] q);
    logic [31:0] r;
    av_xfer(1'b1, 4'h0, {15'h0, wr, ra, d}, r);
    do av_xfer(1'b0, 4'h4, 32'h0, r); while (r[8] !== 1'b0);
    q = r[7:0];
  endtask : cmd

  task automatic wait_init();
    logic [31:0] r;
    do av_xfer(1'b0, 4'h4, 32'h0, r); while (r[10] !== 1'b0);
  endtask : wait_init

  task automatic wait_rise();
    while (link.irq !== 1'b0) @(posedge clk_in);
    while (link.irq !== 1'b1) @(posedge clk_in);
  endtask : wait_rise

  task automatic wait_fall();
    while (link.irq !== 1'b0) @(posedge clk_in);
  endtask : wait_fall

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_after_reset();
    logic [7:0]  q;
    logic [31:0] r;
    wait_init();
    cmd(1'b0, `REG_RESET, 8'h00, q);
    check("reset reg", 32'h0c0, 32'(q));
    cmd(1'b0, `REG_GAIN, 8'h00, q);
    check("gain reg", 32'h0, 32'(q));
    av_xfer(1'b0, 4'h6, 32'h0, r);
  endtask : t_after_reset

  task automatic t_run();
    int          hi;
    int          per;
    int          d;
    logic [7:0]  q;
    logic [31:0] s1;
    logic [31:0] s2;
    cmd(1'b1, `REG_MODE, 8'h01, q);
    d = cycles;
    wait_rise();
    d = cycles - d;
    check("start delay", 32'h1, 32'(d <= STAB_CYC + SAMPLE_CYC + 2 && d >= STAB_CYC + SAMPLE_CYC - 12));
    check("running", 32'h1, 32'(running_out));
    hi = 0;
    per = 0;
    while (link.irq === 1'b1) begin @(posedge clk_in); hi++; end
    while (link.irq !== 1'b1) begin @(posedge clk_in); per++; end
    check("read window", 32'(WIN_CYC), 32'(hi));
    check("sample period", 32'(SAMPLE_CYC), 32'(per + hi));
    wait_fall();
    av_xfer(1'b0, 4'h8, 32'h0, s1);
    wait_rise();
    wait_fall();
    av_xfer(1'b0, 4'h8, 32'h0, s2);
    check("sample count", 32'(s1[31:24] + 8'h01), 32'(s2[31:24]));
    check("new flag", 32'h1, 32'(s2[8]));
    cmd(1'b0, `REG_STATUS, 8'h00, q);
    check("status after read", 32'h0, 32'(q));
  endtask : t_run

  task automatic t_dynamic();
    logic [7:0]  regs [4] = '{`REG_PD2, `REG_CHSEL, `REG_ISC, `REG_GAIN};
    logic [7:0]  q;
    logic [31:0] s1;
    logic [31:0] s2;
    wait_rise();
    wait_fall();
    for (int i = 0; i < 4; i++) begin
      cmd(1'b1, regs[i], 8'h50 | 8'(i), q);
      cmd(1'b0, regs[i], 8'h00, q);
      check("live write", 32'(8'h50 | 8'(i)), 32'(q));
      check("still running", 32'h1, 32'(running_out));
    end
    av_xfer(1'b0, 4'h8, 32'h0, s1);
    wait_rise();
    wait_fall();
    wait_rise();
    wait_fall();
    av_xfer(1'b0, 4'h8, 32'h0, s2);
    check("count after gain", 32'(s1[31:24] + 8'h01), 32'(s2[31:24]));
    check("valid after skip", 32'h0, 32'(s2[9]));
    cmd(1'b1, 8'h0a, 8'h11, q);
    wait_rise();
    check("restarted", 32'h1, 32'(running_out));
  endtask : t_dynamic

  task automatic t_meas_reset();
    logic [7:0]  q;
    logic [31:0] r;
    av_xfer(1'b1, 4'hc, 32'h1, r);
    cmd(1'b1, `REG_RESET, 8'h80, q);
    check("stopped", 32'h0, 32'(running_out));
    cmd(1'b0, `REG_STATUS, 8'h00, q);
    check("status cleared", 32'h0, 32'(q));
    cmd(1'b0, `REG_DATA, 8'h00, q);
    check("data cleared", 32'h0, 32'(q));
    cmd(1'b0, `REG_GAIN, 8'h00, q);
    check("gain kept", 32'h53, 32'(q));
  endtask : t_meas_reset

  task automatic t_full_reset();
    int         t0;
    logic [7:0] q;
    t0 = toggles;
    cmd(1'b1, `REG_RESET, 8'h40, q);
    wait_init();
    check("init toggling", 32'h1, 32'(toggles != t0));
    cmd(1'b0, `REG_RESET, 8'h00, q);
    check("reset reg back", 32'h0c0, 32'(q));
    cmd(1'b0, `REG_GAIN, 8'h00, q);
    check("gain reset", 32'h0, 32'(q));
    check("idle after reset", 32'h0, 32'(running_out));
  endtask : t_full_reset

  initial begin
    repeat (10) @(posedge clk_in);
    rstn_in <= 1'b1;
    @(posedge clk_in);
    t_after_reset();
    t_run();
    t_dynamic();
    t_meas_reset();
    t_full_reset();
    close_out();
  end
endmodule : test_acquisition_reset_and_reconfig_control
